// ==== core/hub_ctrl_defs.vh ====
// Constants for the hub repeater control and status block.
// Assumes a 100 MHz ref_clk; times become cycle counts here.
`ifndef HUB_CTRL_DEFS_VH
`define HUB_CTRL_DEFS_VH

`define CLK_MHZ            100
// Link pulse after 12 ms of transmit idle
`define LINK_TX_MS         12
`define LINK_TX_CYC        (`LINK_TX_MS * 1000 * `CLK_MHZ)
// Link fail after 100 ms of silence
`define LINK_FAIL_MS       100
`define LINK_FAIL_CYC      (`LINK_FAIL_MS * 1000 * `CLK_MHZ)
`define LINK_PASS_PULSES   4
// Jabber lockup, counted in 10 Mb/s bit times
`define BIT_TIME_NS        100
`define BIT_CYC            (`BIT_TIME_NS * `CLK_MHZ / 1000)
`define JAB_LIMIT_BITS     65536
`define JAB_LOCK_BITS      96
// LED times
`define COLLISION_LAMP_N_MS         39
`define CRS_ON_MS          52
`define CRS_OFF_MS         78
`define MS_CYC             (1000 * `CLK_MHZ)
// Reset stretch, in cycles
`define RST_STRETCH_CYC    16
// Serial LED clock toggles every 5 cycles: 10 MHz
`define LED_HALF_CYC       5
`define NUM_TP             8
`define FIFO_DEPTH         8

`endif

// ==== core/exp_fifo.v ====
// Small synchronous FIFO carrying expansion line bits toward the ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module exp_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output reg  [WIDTH-1:0] outData,
    output reg              outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr;
    reg [AW:0]      rdPtr;
    wire            empty = (wrPtr == rdPtr);
    wire            full  = (wrPtr == {~rdPtr[AW], rdPtr[AW-1:0]});
    wire            pop   = !empty && (!outValid || outReady);

    assign inReady = !full;

    // Write side
    always @(posedge ref_clk) begin
        if (inValid && !full)
            mem[wrPtr[AW-1:0]] <= inData;
    end

    // Pointers and registered read data
    always @(posedge ref_clk) begin
        if (rst) begin
            wrPtr    <= {(AW+1){1'b0}};
            rdPtr    <= {(AW+1){1'b0}};
            outValid <= 1'b0;
            outData  <= {WIDTH{1'b0}};
        end else begin
            if (inValid && !full)
                wrPtr <= wrPtr + 1'b1;
            if (pop) begin
                outData  <= mem[rdPtr[AW-1:0]];
                rdPtr    <= rdPtr + 1'b1;
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
        end
    end
endmodule // exp_fifo

// ==== core/led_serializer.v ====
// Shifts an eight-bit LED status byte MSB first, with a byte strobe.
// Assumes led clock enables come from the parent divider.
`timescale 1ns/1ps
module led_serializer (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       fallEn,
    input  wire [7:0] statusByte,
    output reg        serialOut,
    output reg        lastBit
);
    reg [7:0] shiftReg;
    reg [2:0] bitCnt;

    // Load at bit 0, shift on each falling LED clock edge
    always @(posedge ref_clk) begin
        if (rst) begin
            shiftReg  <= 8'h00;
            bitCnt    <= 3'h0;
            serialOut <= 1'b0;
            lastBit   <= 1'b0;
        end else if (fallEn) begin
            if (bitCnt == 3'h0) begin
                serialOut <= statusByte[7];
                shiftReg  <= {statusByte[6:0], 1'b0};
            end else begin
                serialOut <= shiftReg[7];
                shiftReg  <= {shiftReg[6:0], 1'b0};
            end
            lastBit <= (bitCnt == 3'h7);
            bitCnt  <= bitCnt + 3'h1;
        end
    end
endmodule // led_serializer

// ==== core/hub_repeater_ctrl_status.v ====
// Control and status logic of a multiport repeater: link test, jabber,
// reset stretch, expansion port and LED outputs.
// Assumes all inputs synchronous to ref_clk, and port events as pulses.
`timescale 1ns/1ps
`include "hub_ctrl_defs.vh"

// Functional notes
// - Send link pulse after 8 ms transmit idle, before 17 ms.
// - No packet or pulse for 65..132 ms puts a port in link fail.
// - Link fail blocks transmit; four pulses or one packet clear it. Here txEnable ignores tpLinkFail.
// - Link pulses go to every port regardless of state.
// - Transmitting over 65536 bit times cuts transmitters for 96 bits.
// - External reset is stretched into a clean pulse of minimum length.
// - In reset: release two-way pins, low-active outputs high, others low.
// - After reset: line released, transmit idle, partitions cleared, link on.
// - Chips share one NRZ expansion line clocked by the common clock.
// - Active chip asserts request, then drives data or jam on the line.
// - Inactive chip with grant asserted repeats data from the line.
// - Simultaneous requests make every chip transmit jam.
// - Collision LED low between 26 and 52 ms.
// - Attach port carrier LED low 52 ms, then high at least 78 ms.
// - Minimum mode lamp: high in fail, low in pass, 78 ms high on packet.
// - Normal mode serial LED pins send their byte MSB first. Here only link bits shift, port 0 first; pin 6 holds partitionStatus_n[7].
// - Latch captures byte on LED clock rise while strobe is high.
// - Serial LED outputs change on LED clock falling edge.
// - LED clock of 10 MHz derived from the main clock.
module hub_repeater_ctrl_status (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       resetIn_n,
    input  wire       display_mode_sel_a,
    input  wire       display_mode_sel_b,
    input  wire [7:0] tpTxActive,
    input  wire [7:0] tpRxPacket,
    input  wire [7:0] tpRxLinkPulse,
    input  wire       repeatActive,
    input  wire       repeatData,
    input  wire       collisionSeen,
    input  wire       attach1Carrier,
    input  wire       attach2Carrier,
    input  wire [7:0] partitionStatus_n,
    input  wire       expansion_data_line_in,
    input  wire       expansion_grant_n,
    output reg        expansion_data_line_out,
    output reg        expansion_data_line_oe_n,
    output reg        expansion_request_n,
    output wire       expRxData,
    output wire       expRxValid,
    input  wire       expRxReady,
    output wire       expJam,
    output reg  [7:0] tpLinkPulseOut,
    output reg  [7:0] tpLinkFail,
    output reg        txEnable,
    output reg        internalReset,
    output reg        collision_lamp_n,
    output reg        attach_port1_carrier_lamp_n,
    output reg        attach_port2_carrier_lamp_n,
    output reg  [7:0] tp_link_receive_lamp,
    output reg        led_byte_strobe,
    output reg        ledClk
);
    localparam [31:0] LINK_TX_CYC  = `LINK_TX_CYC;
    localparam [31:0] FAIL_CYC     = `LINK_FAIL_CYC;
    localparam [31:0] JAB_LIMIT    = `JAB_LIMIT_BITS * `BIT_CYC;
    localparam [31:0] JAB_LOCK     = `JAB_LOCK_BITS * `BIT_CYC;
    localparam [31:0] COL_CYC      = `COLLISION_LAMP_N_MS * `MS_CYC;
    localparam [31:0] CRS_ON_CYC   = `CRS_ON_MS * `MS_CYC;
    localparam [31:0] CRS_OFF_CYC  = `CRS_OFF_MS * `MS_CYC;
    localparam [4:0]  RST_CYC      = `RST_STRETCH_CYC;
    localparam [2:0]  HALF_CYC     = `LED_HALF_CYC;
    // Expansion states, one-hot
    localparam [2:0]  ST_IDLE = 3'b001;
    localparam [2:0]  ST_DRIVE = 3'b010;
    localparam [2:0]  ST_RECV = 3'b100;

    // Count-down timer step, saturating at zero
    function [31:0] dec;
        input [31:0] v;
        begin
            dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
        end
    endfunction

    // Reset stretcher: any low level restarts the count
    reg [4:0] rstCnt;
    always @(posedge ref_clk) begin
        if (rst || !resetIn_n) begin
            rstCnt        <= RST_CYC;
            internalReset <= 1'b1;
        end else if (rstCnt != 5'h0) begin
            rstCnt        <= rstCnt - 5'h1;
            internalReset <= 1'b1;
        end else begin
            internalReset <= 1'b0;
        end
    end
    wire ir = internalReset;

    // Per-port link test timers
    genvar p;
    generate
        for (p = 0; p < `NUM_TP; p = p + 1) begin : g_port
            reg [31:0] idleCnt;
            reg [31:0] silentCnt;
            reg [2:0]  pulseCnt;
            always @(posedge ref_clk) begin
                if (ir) begin
                    idleCnt           <= LINK_TX_CYC;
                    silentCnt         <= FAIL_CYC;
                    pulseCnt          <= 3'h0;
                    tpLinkPulseOut[p] <= 1'b0;
                    tpLinkFail[p]     <= 1'b0;
                end else begin
                    // Pulse regardless of enable, partition or fail
                    tpLinkPulseOut[p] <= 1'b0;
                    if (tpTxActive[p]) begin
                        idleCnt <= LINK_TX_CYC;
                    end else if (idleCnt == 32'h1) begin
                        tpLinkPulseOut[p] <= 1'b1;
                        idleCnt           <= LINK_TX_CYC;
                    end else begin
                        idleCnt <= dec(idleCnt);
                    end
                    if (tpRxPacket[p] || tpRxLinkPulse[p])
                        silentCnt <= FAIL_CYC;
                    else
                        silentCnt <= dec(silentCnt);
                    if (tpLinkFail[p]) begin
                        if (tpRxPacket[p]) begin
                            tpLinkFail[p] <= 1'b0;
                            pulseCnt      <= 3'h0;
                        end else if (tpRxLinkPulse[p]) begin
                            if (pulseCnt == `LINK_PASS_PULSES - 1) begin
                                tpLinkFail[p] <= 1'b0;
                                pulseCnt      <= 3'h0;
                            end else begin
                                pulseCnt <= pulseCnt + 3'h1;
                            end
                        end
                    end else if (silentCnt == 32'h1 && !tpRxPacket[p] && !tpRxLinkPulse[p]) begin
                        tpLinkFail[p] <= 1'b1;
                        pulseCnt      <= 3'h0;
                    end
                end
            end
        end
    endgenerate

    // Jabber lockup guard
    reg [31:0] jabCnt;
    reg [31:0] lockCnt;
    reg        jabber_lockup_guard;
    always @(posedge ref_clk) begin
        if (ir) begin
            jabCnt              <= 32'h0;
            lockCnt             <= 32'h0;
            jabber_lockup_guard <= 1'b0;
        end else if (jabber_lockup_guard) begin
            if (lockCnt == 32'h1)
                jabber_lockup_guard <= 1'b0;
            lockCnt <= dec(lockCnt);
            jabCnt  <= 32'h0;
        end else if (repeatActive) begin
            if (jabCnt == JAB_LIMIT) begin
                jabber_lockup_guard <= 1'b1;
                lockCnt             <= JAB_LOCK;
                jabCnt              <= 32'h0;
            end else begin
                jabCnt <= jabCnt + 32'h1;
            end
        end else begin
            jabCnt <= 32'h0;
        end
    end

    // Transmit gate: idle in reset and during lockup
    always @(posedge ref_clk) begin
        if (ir)
            txEnable <= 1'b0;
        else
            txEnable <= repeatActive && !jabber_lockup_guard;
    end

    // Expansion port state machine
    reg [2:0] expState;
    reg [2:0] next_expState;
    wire      collide = !expansion_request_n && !expansion_grant_n;
    always @* begin
        case (expState)
            ST_IDLE:  next_expState = repeatActive ? ST_DRIVE :
                                      (!expansion_grant_n ? ST_RECV : ST_IDLE);
            ST_DRIVE: next_expState = repeatActive ? ST_DRIVE : ST_IDLE;
            ST_RECV:  next_expState = repeatActive ? ST_DRIVE :
                                      (!expansion_grant_n ? ST_RECV : ST_IDLE);
            default:  next_expState = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk) begin
        if (ir) begin
            expState                 <= ST_IDLE;
            expansion_request_n      <= 1'b1;
            expansion_data_line_oe_n <= 1'b1;
            expansion_data_line_out  <= 1'b0;
        end else begin
            expState                 <= next_expState;
            expansion_request_n      <= !(next_expState == ST_DRIVE);
            // Drive only after request is already out
            expansion_data_line_oe_n <= !(expState == ST_DRIVE && repeatActive);
            expansion_data_line_out  <= collide ? 1'b1 : repeatData;
        end
    end
    assign expJam = collide;

    // Received expansion bits buffered toward the ports
    exp_fifo #(
        .WIDTH (1),
        .DEPTH (`FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst      (ir),
        .inData   (expansion_data_line_in),
        .inValid  (expState == ST_RECV),
        .inReady  (),
        .outData  (expRxData),
        .outValid (expRxValid),
        .outReady (expRxReady)
    );

    // Collision and attach-port carrier lamps
    reg [31:0] colCnt;
    reg [31:0] crs1Cnt;
    reg [31:0] crs2Cnt;
    reg        crs1Off;
    reg        crs2Off;
    always @(posedge ref_clk) begin
        if (ir) begin
            colCnt                      <= 32'h0;
            crs1Cnt                     <= 32'h0;
            crs2Cnt                     <= 32'h0;
            crs1Off                     <= 1'b0;
            crs2Off                     <= 1'b0;
            collision_lamp_n            <= 1'b1;
            attach_port1_carrier_lamp_n <= 1'b1;
            attach_port2_carrier_lamp_n <= 1'b1;
        end else begin
            if (collisionSeen && colCnt == 32'h0) begin
                colCnt           <= COL_CYC;
                collision_lamp_n <= 1'b0;
            end else begin
                colCnt <= dec(colCnt);
                if (colCnt == 32'h1)
                    collision_lamp_n <= 1'b1;
            end
            // Port 1: on phase then guaranteed off phase
            if (crs1Cnt == 32'h0 && attach1Carrier) begin
                crs1Cnt <= CRS_ON_CYC;
                crs1Off <= 1'b0;
                attach_port1_carrier_lamp_n <= 1'b0;
            end else if (crs1Cnt == 32'h1 && !crs1Off) begin
                crs1Cnt <= CRS_OFF_CYC;
                crs1Off <= 1'b1;
                attach_port1_carrier_lamp_n <= 1'b1;
            end else begin
                crs1Cnt <= dec(crs1Cnt);
            end
            if (crs2Cnt == 32'h0 && attach2Carrier) begin
                crs2Cnt <= CRS_ON_CYC;
                crs2Off <= 1'b0;
                attach_port2_carrier_lamp_n <= 1'b0;
            end else if (crs2Cnt == 32'h1 && !crs2Off) begin
                crs2Cnt <= CRS_OFF_CYC;
                crs2Off <= 1'b1;
                attach_port2_carrier_lamp_n <= 1'b1;
            end else begin
                crs2Cnt <= dec(crs2Cnt);
            end
        end
    end

    // Minimum-mode lamp per port: high 78 ms, then low 52 ms
    wire       normalMode = display_mode_sel_a && display_mode_sel_b;
    wire [7:0] rxLampState;
    generate
        for (p = 0; p < `NUM_TP; p = p + 1) begin : g_lamp
            reg [31:0] blinkCnt;
            reg        blinkHigh;
            always @(posedge ref_clk) begin
                if (ir) begin
                    blinkCnt  <= 32'h0;
                    blinkHigh <= 1'b0;
                end else if (blinkCnt == 32'h0 && tpRxPacket[p]) begin
                    blinkCnt  <= CRS_OFF_CYC;
                    blinkHigh <= 1'b1;
                end else if (blinkCnt == 32'h1 && blinkHigh) begin
                    blinkCnt  <= CRS_ON_CYC;
                    blinkHigh <= 1'b0;
                end else begin
                    blinkCnt <= dec(blinkCnt);
                end
            end
            assign rxLampState[p] = tpLinkFail[p] || blinkHigh;
        end
    endgenerate

    // LED clock divider: 10 MHz, shift enable at each falling edge
    reg [2:0] divCnt;
    wire      halfTick = (divCnt == HALF_CYC - 3'h1);
    wire      fallEn   = halfTick && ledClk;
    always @(posedge ref_clk) begin
        if (ir) begin
            divCnt <= 3'h0;
            ledClk <= 1'b0;
        end else if (halfTick) begin
            divCnt <= 3'h0;
            ledClk <= ~ledClk;
        end else begin
            divCnt <= divCnt + 3'h1;
        end
    end

    // Serial link byte
    wire serialLink;
    wire lastBit;
    led_serializer u_ser (
        .ref_clk    (ref_clk),
        .rst        (ir),
        .fallEn     (fallEn),
        .statusByte ({rxLampState[0], rxLampState[1], rxLampState[2], rxLampState[3],
                      rxLampState[4], rxLampState[5], rxLampState[6], rxLampState[7]}),
        .serialOut  (serialLink),
        .lastBit    (lastBit)
    );

    // Pins by display mode; strobe spans a rising LED edge
    always @(posedge ref_clk) begin
        if (ir) begin
            tp_link_receive_lamp <= 8'h00;
            led_byte_strobe      <= 1'b0;
        end else if (normalMode) begin
            tp_link_receive_lamp <= {lastBit, partitionStatus_n[7], 5'h1f, serialLink};
            led_byte_strobe      <= lastBit;
        end else begin
            tp_link_receive_lamp <= rxLampState;
            led_byte_strobe      <= 1'b0;
        end
    end
endmodule // hub_repeater_ctrl_status

// ==== testbench/hub_ctrl_asserts.sv ====
// Checker for the hub control block, bound to its top ports.
// Assumes one ref_clk domain and synchronous active-high rst.
`timescale 1ns/1ps
module hub_ctrl_asserts (
    input wire       ref_clk,
    input wire       rst,
    input wire       resetIn_n,
    input wire       display_mode_sel_a,
    input wire       display_mode_sel_b,
    input wire       repeatActive,
    input wire       collisionSeen,
    input wire [7:0] tpRxPacket,
    input wire       expansion_grant_n,
    input wire       expansion_data_line_oe_n,
    input wire       expansion_request_n,
    input wire       expJam,
    input wire [7:0] tpLinkFail,
    input wire       internalReset,
    input wire       collision_lamp_n,
    input wire [7:0] tp_link_receive_lamp,
    input wire       led_byte_strobe,
    input wire       ledClk
);
    logic [4:0] quiet;
    logic [3:0] falls;
    logic       primed;
    wire        normal = display_mode_sel_a & display_mode_sel_b;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Cycles since reset let go, and LED clock falls within one frame
    always @(posedge ref_clk) begin
        if (rst || !resetIn_n) quiet <= 5'h00;
        else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
        if (rst || !normal) begin
            falls  <= 4'h0;
            primed <= 1'b0;
        end else if ($rose(led_byte_strobe)) begin
            falls  <= {3'h0, $fell(ledClk)};
            primed <= 1'b1;
        end else if ($fell(ledClk)) falls <= falls + 4'h1;
    end
    reset_outputs_a: assert property (internalReset && $past(internalReset) |->
        expansion_data_line_oe_n && expansion_request_n && collision_lamp_n &&
        !led_byte_strobe && !ledClk && tp_link_receive_lamp == 8'h00)
        else $error("outputs not idle in reset");
    reset_stretch_a: assert property ($fell(internalReset) |->
        quiet >= 5'h0e && quiet <= 5'h12) else $error("reset stretch length wrong");
    req_follow_a: assert property ($rose(repeatActive) && !internalReset |=>
        !expansion_request_n) else $error("request did not follow activity");
    drive_after_req_a: assert property (!expansion_data_line_oe_n |->
        !$past(expansion_request_n)) else $error("line driven without request");
    drive_walk_a: assert property ($fell(expansion_request_n) && repeatActive |=>
        !expansion_data_line_oe_n) else $error("line not driven after request");
    jam_detect_a: assert property (expJam ==
        (!expansion_request_n && !expansion_grant_n)) else $error("jam flag wrong");
    col_lamp_a: assert property (collisionSeen |-> ##[1:3] !collision_lamp_n)
        else $error("collision lamp not lit");
    fail_clear_a: assert property (tpRxPacket[0] |-> ##[1:3] !tpLinkFail[0])
        else $error("packet did not clear link fail");
    led_clk_half_a: assert property (disable iff (rst || internalReset)
        $rose(ledClk) |-> ledClk[*5] ##1 !ledClk) else $error("LED clock half period wrong");
    serial_edge_a: assert property (normal && $past(normal, 2) && !$past(internalReset) &&
        $changed(tp_link_receive_lamp[0]) |-> !ledClk && $past(ledClk, 2))
        else $error("serial bit off edge");
    byte_frame_a: assert property ($rose(led_byte_strobe) && primed |->
        falls == 4'h8) else $error("serial frame not eight bits");
    cover property ($fell(expansion_request_n));
    cover property (expJam);
    cover property ($rose(led_byte_strobe) && primed);
endmodule // hub_ctrl_asserts

bind hub_repeater_ctrl_status hub_ctrl_asserts chk_u (.*);

// ==== testbench/peer_chip_model.sv ====
// Behavioural second repeater chip sharing the expansion line.
// Assumes a two-chip setup: each request wired to the other's grant.
`timescale 1ns/1ps
module peer_chip_model (
    input  wire ref_clk,
    input  wire rst,
    input  wire peerActive,
    input  wire peerData,
    input  wire dutRequest_n,
    input  wire dutLineOut,
    input  wire dutLineOe_n,
    output reg  peerRequest_n,
    output reg  peerOe_n,
    output wire lineLevel
);
    reg peerBit;
    reg lastLevel;
    // Request first, drive the line one cycle later; jam high on contention
    always @(posedge ref_clk) begin
        if (rst) begin
            peerRequest_n <= 1'b1;
            peerOe_n      <= 1'b1;
            lastLevel     <= 1'b0;
        end else begin
            peerRequest_n <= !peerActive;
            peerOe_n      <= peerRequest_n | !peerActive;
            lastLevel     <= lineLevel;
        end
        peerBit <= (!dutRequest_n && !peerRequest_n) ? 1'b1 : peerData;
    end
    // Unpulled line: released, it shows its last level inverted
    assign lineLevel = !dutLineOe_n ? dutLineOut : (!peerOe_n ? peerBit : !lastLevel);
endmodule // peer_chip_model

// ==== testbench/test_hub_repeater_ctrl_status.sv ====
// Self-checking bench for the hub control block and a peer chip.
// Assumes the 100 MHz ref_clk and the constants of the shared header.
`timescale 1ns/1ps
`include "hub_ctrl_defs.vh"
module test_hub_repeater_ctrl_status;
    reg        ref_clk = 1'b0, rst = 1'b1, resetIn_n = 1'b1, selA = 1'b0, selB = 1'b0;
    reg  [7:0] pkt = 8'h00;
    reg        repAct = 1'b0, repData = 1'b0, col = 1'b0, at1 = 1'b0, at2 = 1'b0;
    reg        rxReady = 1'b0, peerAct = 1'b0, peerData = 1'b0, prev;
    wire [7:0] linkFail, lamp;
    wire       lineOut, oe_n, req_n, rxData, rxValid, jam, txEn, intRst, colL_n;
    wire       at1L_n, at2L_n, strobe, ledClk, peerReq_n, peerOe_n, lineLevel;
    integer    err_total = 0, num_checks = 0, cycles = 0, k, t0, t1, seed;
    reg        sent[$], got[$];
    hub_repeater_ctrl_status dut_u (.ref_clk(ref_clk), .rst(rst), .resetIn_n(resetIn_n),
        .display_mode_sel_a(selA), .display_mode_sel_b(selB), .tpTxActive(8'h00),
        .tpRxPacket(pkt), .tpRxLinkPulse(8'h00), .repeatActive(repAct), .repeatData(repData),
        .collisionSeen(col), .attach1Carrier(at1), .attach2Carrier(at2),
        .partitionStatus_n(8'hff), .expansion_data_line_in(lineLevel),
        .expansion_grant_n(peerReq_n), .expansion_data_line_out(lineOut),
        .expansion_data_line_oe_n(oe_n), .expansion_request_n(req_n), .expRxData(rxData),
        .expRxValid(rxValid), .expRxReady(rxReady), .expJam(jam), .tpLinkPulseOut(),
        .tpLinkFail(linkFail), .txEnable(txEn), .internalReset(intRst),
        .collision_lamp_n(colL_n), .attach_port1_carrier_lamp_n(at1L_n),
        .attach_port2_carrier_lamp_n(at2L_n), .tp_link_receive_lamp(lamp),
        .led_byte_strobe(strobe), .ledClk(ledClk));
    peer_chip_model peer_u (.ref_clk(ref_clk), .rst(rst), .peerActive(peerAct),
        .peerData(peerData), .dutRequest_n(req_n), .dutLineOut(lineOut), .dutLineOe_n(oe_n),
        .peerRequest_n(peerReq_n), .peerOe_n(peerOe_n), .lineLevel(lineLevel));
    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    task check(input [31:0] gotV, input [31:0] expV);
        begin
            num_checks = num_checks + 1;
            if (gotV !== expV) begin
                err_total = err_total + 1;
                $display("[ERR] %0t got %h exp %h", $time, gotV, expV);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    // Offset of received bits within sent bits, or -1
    function automatic integer window_at();
        integer o, i, ok;
        begin
            window_at = -1;
            for (o = 3; o >= 0; o = o - 1) begin
                ok = (got.size() > 0);
                for (i = 0; i < got.size(); i = i + 1)
                    if (o + i >= sent.size() || got[i] !== sent[o + i]) ok = 0;
                if (ok) window_at = o;
            end
        end
    endfunction
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        seed = $urandom(26);
        cyc(4);
        check({intRst, oe_n, req_n, colL_n, at1L_n, at2L_n}, 6'h3f);
        check({strobe, ledClk, txEn, lamp}, 11'h000);
        @(posedge ref_clk) rst <= 1'b0;
        cyc(15);
        check(intRst, 1);
        cyc(4);
        check({intRst, oe_n}, 2'h1);
        for (k = 0; k < 3; k = k + 1) begin
            @(posedge ref_clk) resetIn_n <= 1'b0;
            @(posedge ref_clk) resetIn_n <= 1'b1;
        end
        cyc(15);
        check(intRst, 1);
        cyc(4);
        check(intRst, 0);
        $display("reset test done");
        @(posedge ref_clk) repAct <= 1'b1;
        repData <= $urandom;
        cyc(1);
        check({req_n, oe_n}, 2'h1);
        cyc(1);
        check({oe_n, jam}, 2'h0);
        @(posedge ref_clk) peerAct <= 1'b1;
        cyc(3);
        check({jam, lineOut, oe_n}, 3'h6);
        @(posedge ref_clk) repAct <= 1'b0;
        peerAct <= 1'b0;
        cyc(3);
        check({req_n, oe_n}, 2'h3);
        $display("request and jam test done");
        @(posedge ref_clk) peerAct <= 1'b1;
        for (k = 0; k < 20; k = k + 1) begin
            @(posedge ref_clk) peerData <= $urandom;
            #1;
            if (peerReq_n === 1'b0) sent.push_back(lineLevel);
        end
        @(posedge ref_clk) peerAct <= 1'b0;
        for (k = 0; k < 60; k = k + 1) begin
            @(posedge ref_clk);
            if (rxValid === 1'b1 && rxReady === 1'b1) got.push_back(rxData);
            rxReady <= $urandom;
        end
        check(got.size() == `FIFO_DEPTH || got.size() == `FIFO_DEPTH + 1, 1);
        check(window_at() >= 0, 1);
        $display("expansion receive test done");
        @(posedge ref_clk) selA <= 1'b1;
        selB <= 1'b1;
        t0 = 0;
        t1 = 0;
        prev = 1'b1;
        for (k = 1; k < 300 && t1 == 0; k = k + 1) begin
            cyc(1);
            if (strobe === 1'b1 && prev === 1'b0) begin
                if (t0 == 0) t0 = k;
                else t1 = k;
            end
            prev = strobe;
        end
        check(t1 - t0, 80);
        check(lamp[7], strobe);
        t0 = 0;
        for (k = 0; k < 20; k = k + 1) begin
            cyc(1);
            t0 = t0 + ledClk;
        end
        check(t0, 10);
        @(posedge ref_clk) selA <= 1'b0;
        selB <= 1'b0;
        $display("serial lamp test done");
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge ref_clk) pkt <= 8'h01 << k;
            @(posedge ref_clk) pkt <= 8'h00;
            cyc(3);
            check({linkFail[k], lamp[k]}, 2'h1);
        end
        @(posedge ref_clk) {col, at1, at2} <= 3'h7;
        @(posedge ref_clk) {col, at1, at2} <= 3'h0;
        cyc(3);
        check({colL_n, at1L_n, at2L_n}, 3'h0);
        cyc(1000);
        check({colL_n, at1L_n, at2L_n}, 3'h0);
        @(posedge ref_clk) rst <= 1'b1;
        cyc(2);
        check({colL_n, at1L_n, at2L_n, lamp}, 11'h700);
        @(posedge ref_clk) rst <= 1'b0;
        cyc(20);
        $display("lamp and mid-run reset test done");
        end_of_test;
    end
endmodule // test_hub_repeater_ctrl_status
